//--- acc_pkg.sv
package acc_pkg;
   // ***************************************************
   // device register map
   // ***************************************************
   localparam logic [7:0] ROUTE_ADDR  = 8'h0a;
   localparam logic [7:0] RESULT_ADDR = 8'h0b;
   localparam logic [7:0] ADC_ADDR    = 8'h0c;
   localparam logic [7:0] BLOW_ADDR   = 8'h0d;
   localparam logic [7:0] BMID_ADDR   = 8'h0e;
   localparam logic [7:0] BHIGH_ADDR  = 8'h0f;
   localparam logic [6:0] BLOW_RST    = 7'h20;
   localparam logic [6:0] BMID_RST    = 7'h40;
   localparam logic [6:0] BHIGH_RST   = 7'h68;
   localparam logic [6:0] ADC_RST     = 7'h00;
   localparam logic [3:0] ROUTE_RST   = 4'h0;
   localparam logic [3:0] RESULT_RST  = 4'h0;
   localparam int         INS_BIT     = 3;
   localparam int         STD_BIT     = 2;
   localparam int         OMTP_BIT    = 1;
   localparam int         TRI_BIT     = 0;
   localparam int         FIELD_LSB   = 1;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int         DEBOUNCE_MS  = 90;
   localparam int         CLK_KHZ      = 125000;
   localparam int         DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
   localparam int         CNT_W        = 24;
   // ***************************************************
   // controller register map
   // ***************************************************
   localparam logic [3:0] H_DEV_ADDR  = 4'h0;
   localparam logic [3:0] H_DEV_WDATA = 4'h1;
   localparam logic [3:0] H_CMD       = 4'h2;
   localparam logic [3:0] H_STATUS    = 4'h3;
   localparam logic [3:0] H_DEV_RDATA = 4'h4;
   localparam logic [3:0] H_RESULT    = 4'h5;
   localparam int         CMD_RD      = 0;
   localparam int         CMD_WR      = 1;
   localparam int         ST_RVALID   = 0;
   localparam int         ST_EVENT    = 1;
   localparam int         ST_ORDER    = 2;
   localparam int         ST_BUSY     = 3;
   typedef enum logic [1:0] {
      DET_IDLE, DET_DEBOUNCE, DET_RUN, DET_INSERTED
   } det_state_t;
endpackage : acc_pkg

//--- acc_link_if.sv
`timescale 1ns/1ps
interface acc_link_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       ins_rem_event;
   modport dev  (input addr, wdata, wr, rd, output rdata, ins_rem_event);
   modport host (output addr, wdata, wr, rd, input rdata, ins_rem_event);
endinterface : acc_link_if

//--- acc_detect_dev.sv
`timescale 1ns/1ps
// Function
// - routing switch states live, read-only, bits 3:0
// - presence bit 3 set on completed detection, cleared on removal
// - host fetches presence automatically after each event
// - bit 2 flags four-pole sleeve-mic headset
// - bit 1 flags four-pole ring2-mic headset
// - bit 0 flags three-pole headphone
// - type bits change only after completed detection or on removal
// - adc result in bits 7:1, bit 0 zero
// - low boundary writable, reset 20h, key1/key2
// - low boundary kept below mid boundary
// - mid boundary writable, reset 40h, key2/key3
// - mid boundary between low and high
// - high boundary writable, reset 68h, key3/key4
// - high boundary kept above mid boundary
// - falling jack edge starts debounce, then detection
module acc_detect_dev #(
   parameter int DEBOUNCE_CYC = acc_pkg::DEBOUNCE_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   acc_link_if.dev         lk,
   input  wire logic       jack_detect_input,
   input  wire logic       mic_sleeve_switch,
   input  wire logic       mic_ring2_switch,
   input  wire logic       gnd_sense_sleeve_switch,
   input  wire logic       gnd_sense_ring2_switch,
   input  wire logic       det_done,
   input  wire logic [2:0] det_type,
   input  wire logic       adc_valid,
   input  wire logic [6:0] adc_code,
   output logic            detect_start,
   output logic            key_valid,
   output logic [1:0]      key_code
);
   // ***************************************************
   // state
   // ***************************************************
   acc_pkg::det_state_t               state_q;
   logic [acc_pkg::CNT_W-1:0]         cnt_q;
   logic                              jack_prev_q;
   logic [3:0]                        route_q;
   logic [3:0]                        result_q;
   logic [6:0]                        adc_q;
   logic [6:0]                        blow_q;
   logic [6:0]                        bmid_q;
   logic [6:0]                        bhigh_q;
   logic [7:0]                        rdata_q;
   logic                              event_q;
   logic                              detect_start_q;
   logic                              key_valid_q;
   logic [1:0]                        key_code_q;
   logic                              fall;
   logic                              rise;
   logic                              expired;
   logic [1:0]                        key_d;

   assign fall    = jack_prev_q & ~jack_detect_input;
   assign rise    = ~jack_prev_q & jack_detect_input;
   assign expired = (cnt_q == acc_pkg::CNT_W'(DEBOUNCE_CYC - 1));

   assign lk.rdata         = rdata_q;
   assign lk.ins_rem_event = event_q;
   assign detect_start     = detect_start_q;
   assign key_valid        = key_valid_q;
   assign key_code         = key_code_q;

   // ***************************************************
   // jack sequencing
   // ***************************************************
   // reset value high: a jack already low at power-up is seen as inserted
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         jack_prev_q <= 1'b1;
      end else begin
         jack_prev_q <= jack_detect_input;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (state_q == acc_pkg::DET_DEBOUNCE && !expired) begin
         cnt_q <= cnt_q + 1'b1;
      end else begin
         cnt_q <= '0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q        <= acc_pkg::DET_IDLE;
         detect_start_q <= 1'b0;
      end else begin
         detect_start_q <= 1'b0;
         case (state_q)
            acc_pkg::DET_IDLE: begin
               if (fall) begin
                  state_q <= acc_pkg::DET_DEBOUNCE;
               end
            end
            acc_pkg::DET_DEBOUNCE: begin
               // a bounce back high before expiry abandons the insertion
               if (rise) begin
                  state_q <= acc_pkg::DET_IDLE;
               end else if (expired) begin
                  state_q        <= acc_pkg::DET_RUN;
                  detect_start_q <= 1'b1;
               end
            end
            acc_pkg::DET_RUN: begin
               if (rise) begin
                  state_q <= acc_pkg::DET_IDLE;
               end else if (det_done) begin
                  state_q <= acc_pkg::DET_INSERTED;
               end
            end
            acc_pkg::DET_INSERTED: begin
               if (rise) begin
                  state_q <= acc_pkg::DET_IDLE;
               end
            end
            default: begin
               state_q <= acc_pkg::DET_IDLE;
            end
         endcase
      end
   end

   // ***************************************************
   // detection result and event
   // ***************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_q <= acc_pkg::RESULT_RST;
         event_q  <= 1'b0;
      end else begin
         event_q <= 1'b0;
         if (rise && (state_q == acc_pkg::DET_RUN ||
                      state_q == acc_pkg::DET_INSERTED)) begin
            result_q <= acc_pkg::RESULT_RST;
            event_q  <= 1'b1;
         end else if (state_q == acc_pkg::DET_RUN && det_done) begin
            result_q[acc_pkg::INS_BIT]  <= 1'b1;
            result_q[acc_pkg::STD_BIT]  <= det_type[acc_pkg::STD_BIT];
            result_q[acc_pkg::OMTP_BIT] <= det_type[acc_pkg::OMTP_BIT];
            result_q[acc_pkg::TRI_BIT]  <= det_type[acc_pkg::TRI_BIT];
            event_q                     <= 1'b1;
         end
      end
   end

   // ***************************************************
   // live switch states and adc
   // ***************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         route_q <= acc_pkg::ROUTE_RST;
      end else begin
         route_q <= {mic_sleeve_switch, mic_ring2_switch,
                     gnd_sense_sleeve_switch, gnd_sense_ring2_switch};
      end
   end

   // the converter wins over a host write landing in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         adc_q <= acc_pkg::ADC_RST;
      end else if (adc_valid) begin
         adc_q <= adc_code;
      end else if (lk.wr && lk.addr == acc_pkg::ADC_ADDR) begin
         adc_q <= lk.wdata[7:acc_pkg::FIELD_LSB];
      end
   end

   // ***************************************************
   // key boundaries
   // ***************************************************
   // ordering is not checked here but by the host; bad orders simply misclassify
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         blow_q  <= acc_pkg::BLOW_RST;
         bmid_q  <= acc_pkg::BMID_RST;
         bhigh_q <= acc_pkg::BHIGH_RST;
      end else if (lk.wr) begin
         case (lk.addr)
            acc_pkg::BLOW_ADDR: begin
               blow_q <= lk.wdata[7:acc_pkg::FIELD_LSB];
            end
            acc_pkg::BMID_ADDR: begin
               bmid_q <= lk.wdata[7:acc_pkg::FIELD_LSB];
            end
            acc_pkg::BHIGH_ADDR: begin
               bhigh_q <= lk.wdata[7:acc_pkg::FIELD_LSB];
            end
            default: begin
            end
         endcase
      end
   end

   // ***************************************************
   // key classification
   // ***************************************************
   always_comb begin
      if (adc_code < blow_q) begin
         key_d = 2'h0;
      end else if (adc_code < bmid_q) begin
         key_d = 2'h1;
      end else if (adc_code < bhigh_q) begin
         key_d = 2'h2;
      end else begin
         key_d = 2'h3;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         key_valid_q <= 1'b0;
         key_code_q  <= 2'h0;
      end else begin
         key_valid_q <= adc_valid;
         if (adc_valid) begin
            key_code_q <= key_d;
         end
      end
   end

   // ***************************************************
   // read port
   // ***************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (lk.rd) begin
         case (lk.addr)
            acc_pkg::ROUTE_ADDR:  rdata_q <= {4'h0, route_q};
            acc_pkg::RESULT_ADDR: rdata_q <= {4'h0, result_q};
            acc_pkg::ADC_ADDR:    rdata_q <= {adc_q, 1'b0};
            acc_pkg::BLOW_ADDR:   rdata_q <= {blow_q, 1'b0};
            acc_pkg::BMID_ADDR:   rdata_q <= {bmid_q, 1'b0};
            acc_pkg::BHIGH_ADDR:  rdata_q <= {bhigh_q, 1'b0};
            default:              rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
endmodule : acc_detect_dev

//--- acc_detect_host.sv
`timescale 1ns/1ps
module acc_detect_host (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   acc_link_if.host        lk,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata
);
   // ***************************************************
   // state
   // ***************************************************
   logic [7:0] dev_addr_q;
   logic [7:0] dev_wdata_q;
   logic [7:0] dev_rdata_q;
   logic [7:0] result_q;
   logic [7:0] rdata_q;
   logic [7:0] lk_addr_q;
   logic [7:0] lk_wdata_q;
   logic       lk_wr_q;
   logic       lk_rd_q;
   logic       cap_q;
   logic       auto_q;
   logic       cmd_rd_q;
   logic       cmd_wr_q;
   logic       fetch_q;
   logic       event_q;
   logic       rvalid_q;
   logic       order_q;
   logic [6:0] blow_q;
   logic [6:0] bmid_q;
   logic [6:0] bhigh_q;
   logic [6:0] nv;
   logic       idle;
   logic       order_ok;
   logic       cmd_wr_set;
   logic       cmd_rd_set;
   logic       st_wr;

   assign lk.addr  = lk_addr_q;
   assign lk.wdata = lk_wdata_q;
   assign lk.wr    = lk_wr_q;
   assign lk.rd    = lk_rd_q;
   assign rdata    = rdata_q;

   assign nv         = dev_wdata_q[7:acc_pkg::FIELD_LSB];
   assign idle       = !lk_rd_q && !cap_q;
   assign cmd_rd_set = wr && addr == acc_pkg::H_CMD && wdata[acc_pkg::CMD_RD];
   assign cmd_wr_set = wr && addr == acc_pkg::H_CMD && wdata[acc_pkg::CMD_WR];
   assign st_wr      = wr && addr == acc_pkg::H_STATUS;

   // a boundary write that would break the ordering is refused
   always_comb begin
      case (dev_addr_q)
         acc_pkg::BLOW_ADDR:  order_ok = nv < bmid_q;
         acc_pkg::BMID_ADDR:  order_ok = nv > blow_q && nv < bhigh_q;
         acc_pkg::BHIGH_ADDR: order_ok = nv > bmid_q;
         default:             order_ok = 1'b1;
      endcase
   end

   // ***************************************************
   // software registers
   // ***************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_addr_q  <= 8'h00;
         dev_wdata_q <= 8'h00;
      end else if (wr && addr == acc_pkg::H_DEV_ADDR) begin
         dev_addr_q <= wdata;
      end else if (wr && addr == acc_pkg::H_DEV_WDATA) begin
         dev_wdata_q <= wdata;
      end
   end

   // ***************************************************
   // link sequencing
   // ***************************************************
   // the result fetch after an event goes ahead of software commands
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lk_addr_q  <= 8'h00;
         lk_wdata_q <= 8'h00;
         lk_wr_q    <= 1'b0;
         lk_rd_q    <= 1'b0;
         cap_q      <= 1'b0;
         auto_q     <= 1'b0;
         cmd_rd_q   <= 1'b0;
         cmd_wr_q   <= 1'b0;
         fetch_q    <= 1'b0;
      end else begin
         lk_wr_q <= 1'b0;
         lk_rd_q <= 1'b0;
         cap_q   <= lk_rd_q;
         if (idle && fetch_q) begin
            lk_addr_q <= acc_pkg::RESULT_ADDR;
            lk_rd_q   <= 1'b1;
            auto_q    <= 1'b1;
         end else if (idle && cmd_rd_q) begin
            lk_addr_q <= dev_addr_q;
            lk_rd_q   <= 1'b1;
            auto_q    <= 1'b0;
         end else if (idle && cmd_wr_q && order_ok) begin
            lk_addr_q  <= dev_addr_q;
            lk_wdata_q <= dev_wdata_q;
            lk_wr_q    <= 1'b1;
         end
         fetch_q  <= lk.ins_rem_event | (fetch_q & !idle);
         cmd_rd_q <= cmd_rd_set | (cmd_rd_q & !(idle && !fetch_q));
         cmd_wr_q <= cmd_wr_set |
                     (cmd_wr_q & !(idle && !fetch_q && !cmd_rd_q));
      end
   end

   // ***************************************************
   // captured data and shadow boundaries
   // ***************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_rdata_q <= 8'h00;
         result_q    <= 8'h00;
      end else if (cap_q && auto_q) begin
         result_q <= lk.rdata;
      end else if (cap_q) begin
         dev_rdata_q <= lk.rdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         blow_q  <= acc_pkg::BLOW_RST;
         bmid_q  <= acc_pkg::BMID_RST;
         bhigh_q <= acc_pkg::BHIGH_RST;
      end else if (lk_wr_q) begin
         case (lk_addr_q)
            acc_pkg::BLOW_ADDR:  blow_q  <= lk_wdata_q[7:acc_pkg::FIELD_LSB];
            acc_pkg::BMID_ADDR:  bmid_q  <= lk_wdata_q[7:acc_pkg::FIELD_LSB];
            acc_pkg::BHIGH_ADDR: bhigh_q <= lk_wdata_q[7:acc_pkg::FIELD_LSB];
            default: begin
            end
         endcase
      end
   end

   // ***************************************************
   // sticky status, set wins over write-one-to-clear
   // ***************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         event_q  <= 1'b0;
         rvalid_q <= 1'b0;
         order_q  <= 1'b0;
      end else begin
         event_q  <= (cap_q && auto_q) |
                     (event_q & !(st_wr && wdata[acc_pkg::ST_EVENT]));
         rvalid_q <= (cap_q && !auto_q) |
                     (rvalid_q & !(st_wr && wdata[acc_pkg::ST_RVALID]));
         order_q  <= (idle && !fetch_q && !cmd_rd_q && cmd_wr_q &&
                      !order_ok) |
                     (order_q & !(st_wr && wdata[acc_pkg::ST_ORDER]));
      end
   end

   // ***************************************************
   // software read port
   // ***************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (rd) begin
         case (addr)
            acc_pkg::H_DEV_ADDR:  rdata_q <= dev_addr_q;
            acc_pkg::H_DEV_WDATA: rdata_q <= dev_wdata_q;
            acc_pkg::H_STATUS:    rdata_q <= {4'h0,
               cmd_rd_q | cmd_wr_q | fetch_q | !idle,
               order_q, event_q, rvalid_q};
            acc_pkg::H_DEV_RDATA: rdata_q <= dev_rdata_q;
            acc_pkg::H_RESULT:    rdata_q <= result_q;
            default:              rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
endmodule : acc_detect_host

//--- acc_link_assertions.sv
`timescale 1ns/1ps
// ***********************************
// link checker
// ***********************************
module acc_link_assertions (
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       ins_rem_event
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_idle; !rd |=> rdata == 8'h00; endproperty
   a_idle: assert property (p_idle)
      else $error("read data not zero outside a read");
   property p_route;
      rd && addr == acc_pkg::ROUTE_ADDR |=> rdata[7:4] == 4'h0;
   endproperty
   a_route: assert property (p_route)
      else $error("switch state upper bits not zero");
   property p_result;
      rd && addr == acc_pkg::RESULT_ADDR |=> rdata[7:4] == 4'h0;
   endproperty
   a_result: assert property (p_result)
      else $error("result upper bits not zero");
   property p_adc; rd && addr == acc_pkg::ADC_ADDR |=> !rdata[0]; endproperty
   a_adc: assert property (p_adc)
      else $error("adc bit 0 not zero");
   property p_blow; rd && addr == acc_pkg::BLOW_ADDR |=> !rdata[0]; endproperty
   a_blow: assert property (p_blow)
      else $error("low boundary bit 0 not zero");
   property p_bmid; rd && addr == acc_pkg::BMID_ADDR |=> !rdata[0]; endproperty
   a_bmid: assert property (p_bmid)
      else $error("mid boundary bit 0 not zero");
   property p_bhigh;
      rd && addr == acc_pkg::BHIGH_ADDR |=> !rdata[0];
   endproperty
   a_bhigh: assert property (p_bhigh)
      else $error("high boundary bit 0 not zero");
   property p_evt; ins_rem_event |=> !ins_rem_event; endproperty
   a_evt: assert property (p_evt)
      else $error("event longer than one cycle");
   // every event must be followed by a result fetch within 1 to 12 cycles
   property p_fetch;
      ins_rem_event |-> ##[1:12] (rd && addr == acc_pkg::RESULT_ADDR);
   endproperty
   a_fetch: assert property (p_fetch)
      else $error("result not fetched after event");
endmodule : acc_link_assertions

//--- accessory_detect_status_regs_tb.sv
`timescale 1ns/1ps
module accessory_detect_status_regs_tb;
   logic       sys_clk;
   logic       rst_n;
   logic [3:0] sw_addr;
   logic [7:0] sw_wdata;
   logic       sw_wr;
   logic       sw_rd;
   logic [7:0] sw_rdata;
   logic       jack;
   logic [3:0] route_sw;
   logic       det_done;
   logic [2:0] det_type;
   logic       adc_valid;
   logic [6:0] adc_code;
   logic       detect_start;
   logic       key_valid;
   logic [1:0] key_code;
   int         err_count;
   int         num_checks;
   acc_link_if lk ();
   // short debounce keeps the run brief
   acc_detect_dev #(.DEBOUNCE_CYC(20)) i_acc_detect_dev (
      .sys_clk(sys_clk), .rst_n(rst_n), .lk(lk), .jack_detect_input(jack),
      .mic_sleeve_switch(route_sw[3]), .mic_ring2_switch(route_sw[2]),
      .gnd_sense_sleeve_switch(route_sw[1]),
      .gnd_sense_ring2_switch(route_sw[0]), .det_done(det_done),
      .det_type(det_type), .adc_valid(adc_valid), .adc_code(adc_code),
      .detect_start(detect_start), .key_valid(key_valid),
      .key_code(key_code));
   acc_detect_host i_acc_detect_host (
      .sys_clk(sys_clk), .rst_n(rst_n), .lk(lk), .addr(sw_addr),
      .wdata(sw_wdata), .wr(sw_wr), .rd(sw_rd), .rdata(sw_rdata));
   acc_link_assertions i_acc_link_assertions (
      .sys_clk(sys_clk), .rst_n(rst_n), .addr(lk.addr), .wdata(lk.wdata),
      .wr(lk.wr), .rd(lk.rd), .rdata(lk.rdata),
      .ins_rem_event(lk.ins_rem_event));
   // ***********************************
   // helpers
   // ***********************************
   task complete_run;
      if (err_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      num_checks++;
      if (s !== e) begin
         $display("[ERR] %s exp %h got %h", n, e, s);
         err_count++;
      end
   endtask : chk
   task reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      @(posedge sys_clk);
      sw_wr    <= 1'b0;
   endtask : reg_wr
   task reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      sw_addr <= a;
      sw_rd   <= 1'b1;
      @(posedge sys_clk);
      sw_rd   <= 1'b0;
      #1 d = sw_rdata;
   endtask : reg_rd
   task poll(input int b, input logic v);
      logic [7:0] s;
      for (int i = 0; i < 30; i++) begin
         reg_rd(acc_pkg::H_STATUS, s);
         if (s[b] === v) return;
      end
      $display("[ERR] status bit %0d exp %b got timeout", b, v);
      err_count++;
      complete_run();
   endtask : poll
   task dev_rd(input logic [7:0] a, output logic [7:0] d);
      reg_wr(acc_pkg::H_DEV_ADDR, a);
      reg_wr(acc_pkg::H_CMD, 8'h01);
      poll(acc_pkg::ST_RVALID, 1'b1);
      reg_rd(acc_pkg::H_DEV_RDATA, d);
      reg_wr(acc_pkg::H_STATUS, 8'h01);
   endtask : dev_rd
   task dev_wr(input logic [7:0] a, input logic [7:0] d, input logic e);
      logic [7:0] s;
      reg_wr(acc_pkg::H_DEV_ADDR, a);
      reg_wr(acc_pkg::H_DEV_WDATA, d);
      reg_wr(acc_pkg::H_CMD, 8'h02);
      poll(acc_pkg::ST_BUSY, 1'b0);
      reg_rd(acc_pkg::H_STATUS, s);
      chk("order error", {7'h00, e}, {7'h00, s[acc_pkg::ST_ORDER]});
      reg_wr(acc_pkg::H_STATUS, 8'h04);
   endtask : dev_wr
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      dev_rd(a, d);
      chk("device register", e, d);
   endtask : rd_chk
   // ***********************************
   // scenarios
   // ***********************************
   task t_reset;
      logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h80, 8'hd0};
      for (int i = 0; i < 6; i++) begin
         rd_chk(acc_pkg::ROUTE_ADDR + 8'(i), rv[i]);
      end
      rd_chk(8'h10, 8'h00);
   endtask : t_reset
   task t_route;
      @(posedge sys_clk);
      route_sw <= 4'b1010;
      rd_chk(acc_pkg::ROUTE_ADDR, 8'h0a);
      dev_wr(acc_pkg::ROUTE_ADDR, 8'hff, 1'b0);
      dev_wr(acc_pkg::RESULT_ADDR, 8'hff, 1'b0);
      rd_chk(acc_pkg::RESULT_ADDR, 8'h00);
      dev_wr(acc_pkg::ADC_ADDR, 8'h55, 1'b0);
      rd_chk(acc_pkg::ADC_ADDR, 8'h54);
      route_sw <= 4'b0101;
      rd_chk(acc_pkg::ROUTE_ADDR, 8'h05);
   endtask : t_route
   // probe one below and at each boundary
   task t_keys(input logic [6:0] lo, input logic [6:0] mid,
               input logic [6:0] hi);
      logic [6:0] c;
      logic [1:0] e;
      for (int i = 0; i < 6; i++) begin
         c = (i < 2) ? lo : (i < 4) ? mid : hi;
         c = c - 7'(1 - i % 2);
         e = (c < lo) ? 2'd0 : (c < mid) ? 2'd1 : (c < hi) ? 2'd2 : 2'd3;
         @(posedge sys_clk);
         adc_valid <= 1'b1;
         adc_code  <= c;
         @(posedge sys_clk);
         adc_valid <= 1'b0;
         #1 chk("key", {6'h01, e}, {5'h00, key_valid, key_code});
      end
      rd_chk(acc_pkg::ADC_ADDR, {hi, 1'b0});
   endtask : t_keys
   task t_bounds;
      dev_wr(acc_pkg::BLOW_ADDR, 8'h31, 1'b0);
      dev_wr(acc_pkg::BMID_ADDR, 8'h20, 1'b1);
      dev_wr(acc_pkg::BLOW_ADDR, 8'hc0, 1'b1);
      dev_wr(acc_pkg::BHIGH_ADDR, 8'h70, 1'b1);
      dev_wr(acc_pkg::BMID_ADDR, 8'h91, 1'b0);
      rd_chk(acc_pkg::BLOW_ADDR, 8'h30);
      rd_chk(acc_pkg::BMID_ADDR, 8'h90);
      rd_chk(acc_pkg::BHIGH_ADDR, 8'hd0);
   endtask : t_bounds
   task t_jack(input logic [2:0] t);
      logic [7:0] d;
      int         n;
      @(posedge sys_clk);
      jack <= 1'b0;
      for (n = 0; n < 60; n++) begin
         @(posedge sys_clk);
         #1 if (detect_start === 1'b1) break;
      end
      chk("debounce", 8'h01, {7'h00, n >= 20 && n <= 23});
      rd_chk(acc_pkg::RESULT_ADDR, 8'h00);
      @(posedge sys_clk);
      det_done <= 1'b1;
      det_type <= t;
      @(posedge sys_clk);
      det_done <= 1'b0;
      poll(acc_pkg::ST_EVENT, 1'b1);
      reg_rd(acc_pkg::H_RESULT, d);
      chk("result", {4'h0, 1'b1, t}, d);
      reg_wr(acc_pkg::H_STATUS, 8'h02);
      rd_chk(acc_pkg::RESULT_ADDR, {4'h0, 1'b1, t});
      jack <= 1'b1;
      poll(acc_pkg::ST_EVENT, 1'b1);
      reg_rd(acc_pkg::H_RESULT, d);
      chk("removal", 8'h00, d);
      reg_wr(acc_pkg::H_STATUS, 8'h02);
   endtask : t_jack
   // a plug pulled out mid-debounce must not start detection
   task t_abort;
      logic [7:0] s;
      logic       seen;
      seen = 1'b0;
      @(posedge sys_clk);
      jack <= 1'b0;
      repeat (10) @(posedge sys_clk);
      jack <= 1'b1;
      repeat (40) begin
         @(posedge sys_clk);
         #1 if (detect_start === 1'b1) seen = 1'b1;
      end
      chk("aborted start", 8'h00, {7'h00, seen});
      reg_rd(acc_pkg::H_STATUS, s);
      chk("aborted event", 8'h00, {7'h00, s[acc_pkg::ST_EVENT]});
   endtask : t_abort
   // ***********************************
   // main sequence
   // ***********************************
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      rst_n      = 1'b0;
      sw_addr    = 4'h0;
      sw_wdata   = 8'h00;
      sw_wr      = 1'b0;
      sw_rd      = 1'b0;
      jack       = 1'b1;
      route_sw   = 4'h0;
      det_done   = 1'b0;
      det_type   = 3'h0;
      adc_valid  = 1'b0;
      adc_code   = 7'h00;
      err_count  = 0;
      num_checks = 0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_route();
      t_keys(7'h20, 7'h40, 7'h68);
      t_bounds();
      t_keys(7'h18, 7'h48, 7'h68);
      t_jack(3'b100);
      t_jack(3'b010);
      t_jack(3'b001);
      t_abort();
      complete_run();
   end
endmodule : accessory_detect_status_regs_tb
